// *** dsr_pkg.sv ***
// shared constants, types and helpers for the dual serial register port
package dsr_pkg;

   // ==========================================================
   // register file layout
   localparam int         DSR_NREG        = 16;
   localparam int         DSR_IDX_W       = 4;
   localparam logic [3:0] DSR_AXIS_LAST   = 4'h5;
   localparam logic [3:0] DSR_RESET_WR    = 4'h6;
   localparam logic [3:0] DSR_RW_FIRST    = 4'h8;
   localparam logic [3:0] DSR_RW_LAST     = 4'hd;
   localparam logic [3:0] DSR_CTRLC_IDX   = 4'hc;
   localparam logic [3:0] DSR_CTRLB_IDX   = 4'hd;
   localparam logic [3:0] DSR_CTRLA_IDX   = 4'he;
   localparam logic [7:0] DSR_CTRLB_RST   = 8'h42;
   localparam logic [7:0] DSR_OTHER_RST   = 8'h00;
   localparam int         DSR_STRETCH_BIT = 7;

   // ==========================================================
   // serial framing
   localparam logic [5:0] DSR_ADDR_FIXED  = 6'h0c;
   localparam logic [3:0] DSR_BYTE_BITS   = 4'h8;
   localparam logic [4:0] DSR_SPI_CMD_END = 5'h08;
   localparam logic [4:0] DSR_SPI_LAST    = 5'h0f;
   localparam int         DSR_SPI_DIR_BIT = 7;

   typedef enum logic [3:0] {
      DSR_IDLE  = 4'b0000,
      DSR_ADDR  = 4'b0001,
      DSR_AACK  = 4'b0010,
      DSR_PTR   = 4'b0011,
      DSR_PACK  = 4'b0100,
      DSR_WDATA = 4'b0101,
      DSR_WACK  = 4'b0110,
      DSR_HOLD  = 4'b0111,
      DSR_RDATA = 4'b1000,
      DSR_RACK  = 4'b1001,
      DSR_WAITP = 4'b1010
   } dsr_state_t;

   // ==========================================================
   // helpers
   function automatic logic [7:0] dsr_pick(input logic [127:0] vec,
                                           input logic [3:0]   idx);
      dsr_pick = vec[{idx, 3'b000} +: 8];
   endfunction : dsr_pick

   function automatic logic dsr_writable(input logic [3:0] idx);
      dsr_writable = (idx == DSR_RESET_WR) ||
                     ((idx >= DSR_RW_FIRST) && (idx <= DSR_RW_LAST));
   endfunction : dsr_writable

endpackage : dsr_pkg

// *** dsr_spi_link.sv ***
// spi target shifter running on the master's serial clock
`timescale 1ns/1ns
module dsr_spi_link
(
   input  wire logic         spi_clk_in,
   input  wire logic         rstn_in,
   input  wire logic         select_low_in,
   input  wire logic         spi_din_in,
   input  wire logic [127:0] view_in,
   output logic              serial_out_line_out,
   output logic              serial_out_oe_out,
   output logic              wr_toggle_out,
   output logic [3:0]        wr_idx_out,
   output logic [7:0]        wr_data_out
);
   import dsr_pkg::*;

   logic [4:0] cnt_r;
   logic [7:0] cmd_r;
   logic [6:0] dat_r;
   logic [7:0] tx_r;
   logic       rd_r;

   // ==========================================================
   // receive side, sampled on the rising edge
   // select high clears the frame state, so a new frame starts fresh
   always_ff @(posedge spi_clk_in or posedge select_low_in)
   begin
      if (select_low_in)
      begin
         cnt_r <= 5'h00;
         cmd_r <= 8'h00;
         dat_r <= 7'h00;
      end
      else
      begin
         if (cnt_r != 5'h1f)
            cnt_r <= cnt_r + 5'h01;
         if (cnt_r < DSR_SPI_CMD_END)
            cmd_r <= {cmd_r[6:0], spi_din_in};
         else
            dat_r <= {dat_r[5:0], spi_din_in};
      end
   end

   // ==========================================================
   // completed write: word held, toggle announces it
   always_ff @(posedge spi_clk_in)
   begin
      if ((!select_low_in) && (cnt_r == DSR_SPI_LAST) &&
          (!cmd_r[DSR_SPI_DIR_BIT]))
      begin
         wr_idx_out  <= cmd_r[3:0];
         wr_data_out <= {dat_r, spi_din_in};
      end
   end

   // rstn acts without this clock, which may stand still
   always_ff @(posedge spi_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         wr_toggle_out <= 1'b0;
      else if ((!select_low_in) && (cnt_r == DSR_SPI_LAST) &&
               (!cmd_r[DSR_SPI_DIR_BIT]))
         wr_toggle_out <= ~wr_toggle_out;
   end

   // ==========================================================
   // transmit side, launched on the falling edge
   always_ff @(negedge spi_clk_in or posedge select_low_in)
   begin
      if (select_low_in)
      begin
         tx_r <= 8'h00;
         rd_r <= 1'b0;
      end
      else if (cnt_r == DSR_SPI_CMD_END)
      begin
         tx_r <= dsr_pick(view_in, cmd_r[3:0]);
         rd_r <= cmd_r[DSR_SPI_DIR_BIT];
      end
      else if (cnt_r > DSR_SPI_CMD_END)
         tx_r <= {tx_r[6:0], 1'b0};
   end

   assign serial_out_line_out = tx_r[7];
   assign serial_out_oe_out   = rd_r & ~select_low_in;

endmodule : dsr_spi_link

// *** dsr_serial_port.sv ***
// i2c target engine, register file and spi crossing
`timescale 1ns/1ns
// What this block does
// - start (data falls, clock high) marks bus busy
// - first byte: seven address bits, then direction
// - answer only when all seven bits match
// - address is 001100 plus strapped low bit
// - receiver pulls data low through acknowledge clock
// - stop (data rises, clock high) frees bus
// - write: address, pointer, data, each acknowledged
// - pointer advances after each written byte
// - read: pointer write, repeated start, read address
// - pointer advances after each acknowledged read byte
// - hold clock low for conversion when enabled, on reads that start at axis data registers 0 to 5
// - spi select low frames each transfer
// - spi output released while select is high
// - spi write: address byte then data, 16 clocks
// - spi address top bit: 0 write, 1 read
// - spi read returns register byte, 16 clocks
// - every byte shifted most significant bit first
// - stretch enable is control b bit 7, reset 0x42
// - select tied high selects i2c mode
module dsr_serial_port
(
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        spi_clk_in,
   input  wire logic        select_low_in,
   input  wire logic        spi_din_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        addr_sel_in,
   input  wire logic [47:0] axis_data_in,
   input  wire logic [7:0]  status_in,
   input  wire logic        conv_done_in,
   output logic             scl_out,
   output logic             scl_oe_out,
   output logic             sda_out,
   output logic             sda_oe_out,
   output logic             serial_out_line_out,
   output logic             serial_out_oe_out,
   output logic             conv_start_out,
   output logic             conversion_stretch_enable_out,
   output logic [7:0]       second_control_register_out,
   output logic [7:0]       third_control_register_out
);
   import dsr_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic [1:0] sel_s_r;
   logic [1:0] strap_s_r;
   logic [2:0] tgl_s_r;
   logic       spi_wr_tgl;

   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         scl_s_r   <= 3'h7;
         sda_s_r   <= 3'h7;
         sel_s_r   <= 2'h3;
         tgl_s_r   <= 3'h0;
      end
      else
      begin
         scl_s_r   <= {scl_s_r[1:0], scl_in};
         sda_s_r   <= {sda_s_r[1:0], sda_in};
         sel_s_r   <= {sel_s_r[0], select_low_in};
         tgl_s_r   <= {tgl_s_r[1:0], spi_wr_tgl};
      end
   end

   always_ff @(posedge mclk_in)
      strap_s_r <= {strap_s_r[0], addr_sel_in};

   logic scl_hi;
   logic sda_hi;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic i2c_mode;

   assign scl_hi   = scl_s_r[1];
   assign sda_hi   = sda_s_r[1];
   assign scl_rise = scl_s_r[1] & ~scl_s_r[2];
   assign scl_fall = ~scl_s_r[1] & scl_s_r[2];
   assign i2c_mode = sel_s_r[1];
   assign start_ev = i2c_mode & scl_hi & scl_s_r[2] &
                     ~sda_s_r[1] & sda_s_r[2];
   assign stop_ev  = i2c_mode & scl_hi & scl_s_r[2] &
                     sda_s_r[1] & ~sda_s_r[2];

   // ==========================================================
   // address strap, caught once after reset release
   logic strap_r;
   logic strap_done_r;

   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         strap_r      <= 1'b0;
         strap_done_r <= 1'b0;
      end
      else if (!strap_done_r)
      begin
         strap_r      <= strap_s_r[1];
         strap_done_r <= 1'b1;
      end
   end

   // ==========================================================
   // register file and live image
   logic [7:0]   regs_r [DSR_NREG];
   logic [127:0] live;
   logic [127:0] view_r;

   always_comb
   begin
      live = '0;
      for (int i = 0; i < DSR_NREG; i++)
      begin
         if (i <= int'(DSR_AXIS_LAST))
            live[i*8 +: 8] = axis_data_in[(5-i)*8 +: 8];
         else if (i == int'(DSR_CTRLA_IDX))
            live[i*8 +: 8] = status_in;
         else if (dsr_writable(4'(i)))
            live[i*8 +: 8] = regs_r[i];
      end
   end

   // spi reads a snapshot frozen while select is low; the frame
   // is the handshake that keeps the word still across domains
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
         view_r <= '0;
      else if (sel_s_r[1])
         view_r <= live;
   end

   // ==========================================================
   // spi link end
   logic [3:0] spi_wr_idx;
   logic [7:0] spi_wr_data;
   logic       spi_we;

   dsr_spi_link u_spi
   (
      .spi_clk_in          (spi_clk_in),
      .rstn_in             (rstn_in),
      .select_low_in       (select_low_in),
      .spi_din_in          (spi_din_in),
      .view_in             (view_r),
      .serial_out_line_out (serial_out_line_out),
      .serial_out_oe_out   (serial_out_oe_out),
      .wr_toggle_out       (spi_wr_tgl),
      .wr_idx_out          (spi_wr_idx),
      .wr_data_out         (spi_wr_data)
   );

   assign spi_we = tgl_s_r[1] ^ tgl_s_r[2];

   // ==========================================================
   // i2c target engine
   dsr_state_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic [7:0] ptr_r;
   logic       mack_r;
   logic       i2c_we_r;
   logic [3:0] i2c_wa_r;
   logic [7:0] i2c_wd_r;
   logic       sda_oe_r;
   logic       scl_oe_r;
   logic       conv_r;
   logic [7:0] rx_byte;
   logic [7:0] ptr_byte;
   logic [7:0] nxt_byte;
   logic       rel_r;

   assign rx_byte  = {rx_r[6:0], sda_hi};
   assign ptr_byte = dsr_pick(live, ptr_r[3:0]);
   assign nxt_byte = dsr_pick(live, ptr_r[3:0] + 4'h1);

   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         state_r  <= DSR_IDLE;
         cnt_r    <= 4'h0;
         rx_r     <= 8'h00;
         tx_r     <= 8'h00;
         ptr_r    <= 8'h00;
         mack_r   <= 1'b0;
         i2c_we_r <= 1'b0;
         i2c_wa_r <= 4'h0;
         i2c_wd_r <= 8'h00;
         sda_oe_r <= 1'b0;
         scl_oe_r <= 1'b0;
         conv_r   <= 1'b0;
         rel_r    <= 1'b0;
      end
      else
      begin
         i2c_we_r <= 1'b0;
         conv_r   <= 1'b0;
         rel_r    <= conv_done_in && (state_r == DSR_HOLD);
         if (stop_ev || !i2c_mode)
         begin
            state_r  <= DSR_IDLE;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
         end
         else if (start_ev)
         begin
            state_r  <= DSR_ADDR;
            cnt_r    <= 4'h0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
         end
         else
         begin
            case (state_r)
               DSR_ADDR, DSR_PTR, DSR_WDATA:
               begin
                  if (scl_rise && (cnt_r != DSR_BYTE_BITS))
                  begin
                     rx_r  <= rx_byte;
                     cnt_r <= cnt_r + 4'h1;
                  end
                  else if (scl_fall && (cnt_r == DSR_BYTE_BITS))
                  begin
                     cnt_r <= 4'h0;
                     if (state_r == DSR_ADDR)
                     begin
                        if (rx_r[7:1] == {DSR_ADDR_FIXED, strap_r})
                        begin
                           mack_r   <= rx_r[0];
                           sda_oe_r <= 1'b1;
                           state_r  <= DSR_AACK;
                        end
                        else
                           state_r <= DSR_WAITP;
                     end
                     else if (state_r == DSR_PTR)
                     begin
                        ptr_r    <= rx_r;
                        sda_oe_r <= 1'b1;
                        state_r  <= DSR_PACK;
                     end
                     else
                     begin
                        i2c_we_r <= 1'b1;
                        i2c_wa_r <= ptr_r[3:0];
                        i2c_wd_r <= rx_r;
                        ptr_r    <= ptr_r + 8'h01;
                        sda_oe_r <= 1'b1;
                        state_r  <= DSR_WACK;
                     end
                  end
               end
               DSR_AACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_r <= 1'b0;
                     if (!mack_r)
                        state_r <= DSR_PTR;
                     else if (regs_r[DSR_CTRLB_IDX][DSR_STRETCH_BIT] &&
                              (ptr_r[3:0] <= DSR_AXIS_LAST))
                     begin
                        scl_oe_r <= 1'b1;
                        conv_r   <= 1'b1;
                        state_r  <= DSR_HOLD;
                     end
                     else
                     begin
                        tx_r     <= ptr_byte;
                        sda_oe_r <= ~ptr_byte[7];
                        state_r  <= DSR_RDATA;
                     end
                  end
               end
               DSR_PACK, DSR_WACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_r <= 1'b0;
                     state_r  <= DSR_WDATA;
                  end
               end
               DSR_HOLD:
               begin
                  // data is set up before the clock is let go
                  if (rel_r)
                  begin
                     scl_oe_r <= 1'b0;
                     state_r  <= DSR_RDATA;
                  end
                  else if (conv_done_in)
                  begin
                     tx_r     <= ptr_byte;
                     sda_oe_r <= ~ptr_byte[7];
                  end
               end
               DSR_RDATA:
               begin
                  if (scl_rise)
                     cnt_r <= cnt_r + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_r == DSR_BYTE_BITS)
                     begin
                        cnt_r    <= 4'h0;
                        sda_oe_r <= 1'b0;
                        state_r  <= DSR_RACK;
                     end
                     else
                     begin
                        tx_r     <= {tx_r[6:0], 1'b0};
                        sda_oe_r <= ~tx_r[6];
                     end
                  end
               end
               DSR_RACK:
               begin
                  if (scl_rise)
                     mack_r <= ~sda_hi;
                  else if (scl_fall)
                  begin
                     if (mack_r)
                     begin
                        tx_r     <= nxt_byte;
                        sda_oe_r <= ~nxt_byte[7];
                        ptr_r    <= ptr_r + 8'h01;
                        state_r  <= DSR_RDATA;
                     end
                     else
                        state_r <= DSR_WAITP;
                  end
               end
               DSR_WAITP, DSR_IDLE:
               begin
                  sda_oe_r <= 1'b0;
                  scl_oe_r <= 1'b0;
               end
               default:
                  state_r <= DSR_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // register writes from either port
   always_ff @(posedge mclk_in)
   begin
      if (!rstn_in)
      begin
         for (int i = 0; i < DSR_NREG; i++)
            regs_r[i] <= DSR_OTHER_RST;
         regs_r[DSR_CTRLB_IDX] <= DSR_CTRLB_RST;
      end
      else if (spi_we && dsr_writable(spi_wr_idx))
         regs_r[spi_wr_idx] <= spi_wr_data;
      else if (i2c_we_r && dsr_writable(i2c_wa_r))
         regs_r[i2c_wa_r] <= i2c_wd_r;
   end

   // ==========================================================
   // outputs; open drain lines only ever pull low
   assign scl_out    = 1'b0;
   assign sda_out    = 1'b0;
   assign scl_oe_out = scl_oe_r;
   assign sda_oe_out = sda_oe_r;
   assign conv_start_out = conv_r;
   assign conversion_stretch_enable_out =
      regs_r[DSR_CTRLB_IDX][DSR_STRETCH_BIT];
   assign second_control_register_out = regs_r[DSR_CTRLB_IDX];
   assign third_control_register_out  = regs_r[DSR_CTRLC_IDX];

endmodule : dsr_serial_port

// *** dsr_serial_port_props.sv ***
// concurrent checks on the serial register port outputs
`timescale 1ns/1ns
module dsr_serial_port_props
(
   input wire logic       mclk_in,
   input wire logic       rstn_in,
   input wire logic       select_low_in,
   input wire logic       scl_in,
   input wire logic       conv_done_in,
   input wire logic       scl_out,
   input wire logic       scl_oe_out,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       serial_out_oe_out,
   input wire logic       conv_start_out,
   input wire logic       conversion_stretch_enable_out,
   input wire logic [7:0] second_control_register_out
);
   import dsr_pkg::*;
   // ====================
   // clocking
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);
   // ====================
   // assertions
   a_spi_out_released: assert property (
      serial_out_oe_out |-> !select_low_in)
      else $error("spi output driven while not selected");
   a_i2c_idle_spi: assert property (
      (!select_low_in) [*4] |-> !sda_oe_out && !scl_oe_out)
      else $error("i2c lines pulled during spi frame");
   a_open_drain: assert property (
      scl_out == 1'b0 && sda_out == 1'b0)
      else $error("i2c line driven high");
   a_sda_steady_high: assert property (
      $changed(sda_oe_out) |-> !scl_in)
      else $error("data line moved while clock high");
   a_hold_gate: assert property (
      $rose(scl_oe_out) |-> conversion_stretch_enable_out)
      else $error("clock held with stretching disabled");
   a_hold_start: assert property (
      $rose(scl_oe_out) |-> conv_start_out)
      else $error("clock held without conversion start");
   a_start_pulse: assert property (
      conv_start_out |=> !conv_start_out)
      else $error("conversion start longer than a cycle");
   a_hold_keep: assert property (
      scl_oe_out && !conv_done_in && !$past(conv_done_in) |=> scl_oe_out)
      else $error("clock released before conversion end");
   a_hold_end: assert property (
      scl_oe_out && conv_done_in |-> ##2 !scl_oe_out)
      else $error("clock not released after conversion");
   a_stretch_bit: assert property (
      conversion_stretch_enable_out ==
      second_control_register_out[DSR_STRETCH_BIT])
      else $error("stretch enable differs from control bit");
   a_reset_value: assert property (
      $rose(rstn_in) |-> second_control_register_out == 8'h42)
      else $error("control register wrong after reset");
endmodule : dsr_serial_port_props

bind dsr_serial_port dsr_serial_port_props dsr_serial_port_props_i
(
   .mclk_in                       (mclk_in),
   .rstn_in                       (rstn_in),
   .select_low_in                 (select_low_in),
   .scl_in                        (scl_in),
   .conv_done_in                  (conv_done_in),
   .scl_out                       (scl_out),
   .scl_oe_out                    (scl_oe_out),
   .sda_out                       (sda_out),
   .sda_oe_out                    (sda_oe_out),
   .serial_out_oe_out             (serial_out_oe_out),
   .conv_start_out                (conv_start_out),
   .conversion_stretch_enable_out (conversion_stretch_enable_out),
   .second_control_register_out   (second_control_register_out)
);

// *** dsr_host_model.sv ***
// host master model driving both the i2c and spi sides
`timescale 1ns/1ns
module dsr_host_model
(
   input  wire logic scl_oe_in,
   input  wire logic sda_oe_in,
   input  wire logic serial_out_line_in,
   input  wire logic serial_out_oe_in,
   output logic      scl_out,
   output logic      sda_out,
   output logic      spi_clk_out,
   output logic      select_low_out,
   output logic      spi_din_out,
   output logic      hang_out
);
   localparam int Q = 20;
   logic pull_scl;
   logic pull_sda;
   // ====================
   // pull-ups: a released line reads high
   assign scl_out = !(pull_scl || scl_oe_in);
   assign sda_out = !(pull_sda || sda_oe_in);
   initial
   begin
      pull_scl = 1'b0;
      pull_sda = 1'b0;
      spi_clk_out = 1'b0;
      select_low_out = 1'b1;
      spi_din_out = 1'b0;
      hang_out = 1'b0;
   end
   // ====================
   // i2c bit level
   task automatic bit_x(input logic b, output logic r);
      int n;
      pull_sda = !b;
      #Q;
      pull_scl = 1'b0;
      n = 0;
      while (!scl_out && n < 20000) // wait out a held clock
      begin
         #1;
         n++;
      end
      if (n >= 20000)
         hang_out = 1'b1;
      #Q;
      r = sda_out;
      pull_scl = 1'b1;
      #Q;
   endtask : bit_x
   task automatic start();
      pull_sda = 1'b0;
      #Q;
      pull_scl = 1'b0;
      #Q;
      pull_sda = 1'b1; // data falls with clock high
      #Q;
      pull_scl = 1'b1;
      #Q;
   endtask : start
   task automatic stop();
      pull_sda = 1'b1;
      #Q;
      pull_scl = 1'b0;
      #Q;
      pull_sda = 1'b0; // data rises with clock high
      #Q;
   endtask : stop
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r); // msb first
      bit_x(1'b1, r);
      ack = !r;
   endtask : wr_byte
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(!more, r); // ack all but the last
   endtask : rd_byte
   // ====================
   // spi frame, clock only runs inside it
   task automatic spi_xfer(input logic [15:0] tx, output logic [7:0] rx);
      select_low_out = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_din_out = tx[i];
         #3;
         spi_clk_out = 1'b1;
         if (i < 8)
            rx[i] = serial_out_oe_in ? serial_out_line_in : 1'bx;
         #3;
         spi_clk_out = 1'b0;
      end
      #3;
      select_low_out = 1'b1;
      spi_din_out = !spi_din_out;
      #130;
   endtask : spi_xfer
endmodule : dsr_host_model

// *** tb_dual_serial_register_port.sv ***
// self-checking bench for the dual serial register port
`timescale 1ns/1ns
module tb_dual_serial_register_port;
   import dsr_pkg::*;
   logic        mclk_in, rstn_in, addr_sel, conv_done, hang, ack;
   logic        spi_clk, select_low, spi_din, scl, sda, stretch_en;
   logic        scl_o, scl_oe, sda_o, sda_oe, serial_out_line, sdo_oe, conv_start;
   logic [7:0]  ctrl_b, ctrl_c, rx, d, b, r0, r1, status;
   logic [47:0] axis;
   int          seed, n_mismatch, checks_done, k, n;
   // ====================
   // design and host
   dsr_serial_port dsr_serial_port_i
   (
      .mclk_in                       (mclk_in),
      .rstn_in                       (rstn_in),
      .spi_clk_in                    (spi_clk),
      .select_low_in                 (select_low),
      .spi_din_in                    (spi_din),
      .scl_in                        (scl),
      .sda_in                        (sda),
      .addr_sel_in                   (addr_sel),
      .axis_data_in                  (axis),
      .status_in                     (status),
      .conv_done_in                  (conv_done),
      .scl_out                       (scl_o),
      .scl_oe_out                    (scl_oe),
      .sda_out                       (sda_o),
      .sda_oe_out                    (sda_oe),
      .serial_out_line_out           (serial_out_line),
      .serial_out_oe_out             (sdo_oe),
      .conv_start_out                (conv_start),
      .conversion_stretch_enable_out (stretch_en),
      .second_control_register_out   (ctrl_b),
      .third_control_register_out    (ctrl_c)
   );
   dsr_host_model dsr_host_model_i
   (
      .scl_oe_in          (scl_oe),
      .sda_oe_in          (sda_oe),
      .serial_out_line_in (serial_out_line),
      .serial_out_oe_in   (sdo_oe),
      .scl_out            (scl),
      .sda_out            (sda),
      .spi_clk_out        (spi_clk),
      .select_low_out     (select_low),
      .spi_din_out        (spi_din),
      .hang_out           (hang)
   );
   // ====================
   // helpers
   function automatic logic [7:0] exp_addr(input logic rd);
      exp_addr = {6'h0c, addr_sel, rd};
   endfunction : exp_addr
   task automatic complete_run();
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic send(input logic [7:0] v);
      dsr_host_model_i.wr_byte(v, ack);
      chk({7'h00, ack}, 8'h01);
   endtask : send
   task automatic i2c_ptr(input logic [7:0] ptr);
      dsr_host_model_i.start();
      send(exp_addr(1'b0));
      send(ptr);
   endtask : i2c_ptr
   task automatic i2c_wr(input logic [7:0] p, input logic [7:0] x,
                         input logic [7:0] y);
      i2c_ptr(p);
      send(x);
      send(y);
      dsr_host_model_i.stop();
   endtask : i2c_wr
   task automatic i2c_rd(input logic [7:0] p);
      i2c_ptr(p);
      dsr_host_model_i.start();
      send(exp_addr(1'b1));
      dsr_host_model_i.rd_byte(1'b1, r0);
      dsr_host_model_i.rd_byte(1'b0, r1);
      dsr_host_model_i.stop();
   endtask : i2c_rd
   // ====================
   // clock and watchdogs
   initial
   begin
      mclk_in = 1'b0;
      forever #2 mclk_in = !mclk_in;
   end
   always @(posedge hang)
   begin
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      #150000;
      n_mismatch++;
      complete_run();
   end
   // ====================
   // scenarios
   initial
   begin
      seed = 52836;
      n_mismatch = 0;
      checks_done = 0;
      rstn_in = 1'b0;
      conv_done = 1'b0;
      addr_sel = 1'($random(seed));
      axis = {16'($random(seed)), 32'($random(seed))};
      status = 8'($random(seed));
      repeat (12) @(posedge mclk_in);
      #1 rstn_in = 1'b1;
      repeat (8) @(posedge mclk_in);
      dsr_host_model_i.spi_xfer(16'h8d00, rx);
      chk(rx, 8'h42);
      for (k = 8; k <= 13; k++) // program registers 8 to 13 first
      begin
         d = 8'($random(seed)) & 8'h7f;
         dsr_host_model_i.spi_xfer({4'h0, 4'(k), d}, rx);
         dsr_host_model_i.spi_xfer({4'h8, 4'(k), 8'h00}, rx);
         chk(rx, d);
      end
      chk(ctrl_b, d);
      dsr_host_model_i.spi_xfer({8'h00, ~axis[47:40]}, rx);
      dsr_host_model_i.spi_xfer(16'h8000, rx);
      chk(rx, axis[47:40]);
      d = 8'($random(seed));
      b = 8'($random(seed)) & 8'h7f;
      i2c_wr(8'h0c, d, b);
      chk(ctrl_c, d);
      chk(ctrl_b, b);
      i2c_rd(8'h0c);
      chk(r0, d);
      chk(r1, b);
      dsr_host_model_i.start();
      dsr_host_model_i.wr_byte({6'h0c, !addr_sel, 1'b0}, ack);
      chk({7'h00, ack}, 8'h00);
      dsr_host_model_i.stop();
      i2c_wr(8'h0d, b | 8'h80, 8'h00);
      chk({7'h00, stretch_en}, 8'h01);
      fork
         i2c_rd(8'h00);
         begin
            n = 0;
            while (n < 5000 && conv_start !== 1'b1)
            begin
               @(posedge mclk_in);
               #1 n++;
            end
            chk({7'h00, conv_start}, 8'h01);
            repeat (30) @(posedge mclk_in);
            #1 conv_done = 1'b1;
            @(posedge mclk_in);
            #1 conv_done = 1'b0;
         end
      join
      chk(r0, axis[47:40]);
      chk(r1, axis[39:32]);
      @(posedge mclk_in);
      #1 rstn_in = 1'b0;
      addr_sel = !addr_sel;
      repeat (4) @(posedge mclk_in);
      #1 rstn_in = 1'b1;
      repeat (8) @(posedge mclk_in);
      chk(ctrl_b, 8'h42);
      i2c_ptr(8'h0c);
      dsr_host_model_i.stop();
      complete_run();
   end
endmodule : tb_dual_serial_register_port
